// file: inc/bfdm_pkg.sv
`default_nettype none
package bfdm_pkg;
    // Operation codes presented on the op port
    typedef enum logic [4:0] {
        IDLE_CYCLE_OP = 5'h00,
        IO_BIT_CLEAR_OP = 5'h01,
        IO_BIT_SET_OP = 5'h02,
        BIT_TO_TFLAG_OP = 5'h03,
        TFLAG_TO_BIT_OP = 5'h04,
        FLAG_SET_OP = 5'h05,
        FLAG_CLEAR_OP = 5'h06,
        REGISTER_COPY_OP = 5'h07,
        IMMEDIATE_LOAD_OP = 5'h08,
        INDIRECT_LOAD_OP = 5'h09,
        INDIRECT_LOAD_INC_OP = 5'h0A,
        INDIRECT_LOAD_DEC_OP = 5'h0B,
        INDIRECT_WRITE_OP = 5'h0C,
        INDIRECT_WRITE_INC_OP = 5'h0D,
        INDIRECT_WRITE_DEC_OP = 5'h0E,
        DIRECT_LOAD_OP = 5'h0F,
        DIRECT_WRITE_OP = 5'h10,
        IO_READ_OP = 5'h11,
        IO_WRITE_OP = 5'h12,
        STACK_SAVE_OP = 5'h13,
        STACK_RESTORE_OP = 5'h14,
        DEBUG_HALT_OP = 5'h15,
        LOW_POWER_OP = 5'h16,
        WATCHDOG_RESTART_OP = 5'h17
    } bfdm_op_type;

    // Sequencer states for multi-cycle operations
    typedef enum logic [2:0] {
        S_IDLE = 3'h0,
        S_HOLD = 3'h1,
        S_PREDEC_LOAD = 3'h2,
        S_PREDEC_WRITE = 3'h3,
        S_RESTORE_READ = 3'h4
    } bfdm_state_type;

    // Status flag bit positions
    localparam logic [2:0] FLAG_C_POS = 3'h0;
    localparam logic [2:0] FLAG_Z_POS = 3'h1;
    localparam logic [2:0] FLAG_N_POS = 3'h2;
    localparam logic [2:0] FLAG_V_POS = 3'h3;
    localparam logic [2:0] FLAG_S_POS = 3'h4;
    localparam logic [2:0] FLAG_H_POS = 3'h5;
    localparam logic [2:0] FLAG_T_POS = 3'h6;
    localparam logic [2:0] FLAG_I_POS = 3'h7;

    // Pointer pair low-byte register indices
    localparam logic [3:0] PTR_X_LO_IDX = 4'hA;
    localparam logic [3:0] PTR_Y_LO_IDX = 4'hC;
    localparam logic [3:0] PTR_Z_LO_IDX = 4'hE;

    // Values after reset
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [15:0] STACK_RESET = 16'h00FF;
    localparam int REG_COUNT = 16;
endpackage
`default_nettype wire

// file: rtl/bfdm_flags.sv
`timescale 1ns/1ps
`default_nettype none
module bfdm_flags
    import bfdm_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic en,
    input wire logic set_en,
    input wire logic clr_en,
    input wire logic [2:0] sel,
    input wire logic t_we,
    input wire logic t_val,
    output logic [7:0] flags
);
    // One status bit per slice; only the selected bit, or the T bit on t_we, may move
    for (genvar i = 0; i < 8; i++) begin : g_flag
        always_ff @(posedge clk) begin
            if (rst) begin
                flags[i] <= FLAGS_RESET[i];
            end else if (en && (set_en || clr_en) && sel == 3'(i)) begin
                if (set_en) begin
                    flags[i] <= 1'b1; // [RL5]
                end else if (clr_en) begin
                    flags[i] <= 1'b0; // [RL5]
                end
            end else if (en && t_we && FLAG_T_POS == 3'(i)) begin
                flags[i] <= t_val; // [RL3]
            end
        end
    end

    a_flag_single: assert property (@(posedge clk) disable iff (rst) // [RL5]
        en && (set_en || clr_en) |=> flags == ($past(set_en) ? ($past(flags) | (8'h01 << $past(sel)))
            : ($past(flags) & ~(8'h01 << $past(sel)))))
        else $error("flag set/clear touched the wrong bits");
endmodule
`default_nettype wire

// file: rtl/bfdm_exec.sv
// Overview of operation
// RL1: I/O bit clear, one cycle, flags kept
// RL2: I/O bit set, one cycle, flags kept
// RL3: Register bit copied into T flag
// RL4: T flag written into register bit
// RL5: Single flag set or clear, one cycle
// RL6: Indirect load; post-increment form takes two
// RL7: Pre-decrement load: decrement, then read, three
// RL8: Indirect store, post-increment too, one cycle
// RL9: Pre-decrement store: decrement, then write, two
// RL10: Direct load from constant address, one cycle
// RL11: Direct store to constant address, one cycle
// RL12: I/O read and write, one cycle each
// RL13: Stack save takes two cycles, flags kept
// RL14: Stack restore takes two cycles, flags kept
// RL15: Control operations one cycle, flags untouched
// RL16: Copy and immediate load, one cycle
// RL17: Pointer update wraps, no flag change
`timescale 1ns/1ps
`default_nettype none
module bfdm_exec
    import bfdm_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic SYS_RST,
    input wire logic CLK_EN,
    input wire logic OP_VALID,
    input wire bfdm_pkg::bfdm_op_type OP_CODE,
    input wire logic [3:0] OP_RD,
    input wire logic [3:0] OP_RR,
    input wire logic [2:0] OP_BIT,
    input wire logic [7:0] OP_IMM,
    input wire logic [15:0] OP_ADDR,
    input wire logic [1:0] OP_PTR,
    output logic OP_READY,
    output logic [15:0] DMEM_ADDR,
    output logic [7:0] DMEM_WDATA,
    output logic DMEM_WE,
    output logic DMEM_RE,
    input wire logic [7:0] DMEM_RDATA,
    output logic [5:0] IO_ADDR,
    output logic [7:0] IO_WDATA,
    output logic IO_WE,
    output logic IO_RE,
    input wire logic [7:0] IO_RDATA,
    output logic [7:0] IO_BIT_MASK,
    output logic IO_BIT_CLR,
    output logic IO_BIT_SET,
    output logic [7:0] FLAGS,
    output logic [15:0] STACK_PTR,
    output logic BREAK_REQ,
    output logic SLEEP_REQ,
    output logic WDOG_KICK,
    input wire logic [3:0] DBG_SEL,
    output logic [7:0] DBG_DATA
);
    import bfdm_pkg::*;

    logic [7:0] regs [REG_COUNT];
    bfdm_state_type state, next_state;
    logic accept;
    logic wb_pend, wb_from_io;
    logic [3:0] wb_idx, held_rd, held_lo;
    logic [7:0] held_data, wb_data;
    logic [3:0] ptr_lo, ptr_hi, dec_lo;
    logic [15:0] ptr_cur, ptr_held;
    logic op_we, ptr_we, rd_go, rd_io, mw_go, io_w_go, io_clr, io_set;
    logic t_we, f_set, f_clr, sp_inc, sp_dec;
    logic [3:0] op_idx, rd_dst;
    logic [7:0] op_wdata, mw_data, rr_val;
    logic [15:0] ptr_wval, rd_addr, mw_addr;

    assign accept = CLK_EN && OP_VALID && OP_READY;
    assign wb_data = wb_from_io ? IO_RDATA : DMEM_RDATA;

    // Register read with bypass of the load landing this cycle
    function automatic logic [7:0] reg_val(input logic [3:0] idx);
        reg_val = (wb_pend && wb_idx == idx) ? wb_data : regs[idx];
    endfunction

    // Pointer pair selection
    always_comb begin
        unique case (OP_PTR)
            2'h0: ptr_lo = PTR_X_LO_IDX;
            2'h1: ptr_lo = PTR_Y_LO_IDX;
            default: ptr_lo = PTR_Z_LO_IDX;
        endcase
    end
    assign ptr_hi = ptr_lo | 4'h1;
    assign dec_lo = held_lo | 4'h1;
    assign ptr_cur = {reg_val(ptr_hi), reg_val(ptr_lo)};
    assign ptr_held = {reg_val(dec_lo), reg_val(held_lo)};
    assign rr_val = reg_val(OP_RR);

    // Sequencing of multi-cycle operations
    always_comb begin
        next_state = S_IDLE;
        unique case (state)
            S_IDLE: begin
                if (accept) begin
                    case (OP_CODE)
                        INDIRECT_LOAD_INC_OP, STACK_SAVE_OP: next_state = S_HOLD; // [RL6] [RL13]
                        INDIRECT_LOAD_DEC_OP: next_state = S_PREDEC_LOAD; // [RL7]
                        INDIRECT_WRITE_DEC_OP: next_state = S_PREDEC_WRITE; // [RL9]
                        STACK_RESTORE_OP: next_state = S_RESTORE_READ; // [RL14]
                        default: next_state = S_IDLE;
                    endcase
                end
            end
            S_PREDEC_LOAD: next_state = S_HOLD;
            S_HOLD, S_PREDEC_WRITE, S_RESTORE_READ: next_state = S_IDLE;
            default: next_state = S_IDLE;
        endcase
    end

    // Operation decode into register, memory and flag actions
    always_comb begin
        op_we = 1'b0; op_idx = OP_RD; op_wdata = OP_IMM;
        ptr_we = 1'b0; ptr_wval = ptr_cur + 16'h0001;
        rd_go = 1'b0; rd_io = 1'b0; rd_dst = OP_RD; rd_addr = ptr_cur;
        mw_go = 1'b0; mw_addr = ptr_cur; mw_data = rr_val;
        io_w_go = 1'b0; io_clr = 1'b0; io_set = 1'b0;
        t_we = 1'b0; f_set = 1'b0; f_clr = 1'b0; sp_inc = 1'b0; sp_dec = 1'b0;
        if (accept) begin
            case (OP_CODE)
                IO_BIT_CLEAR_OP: io_clr = 1'b1; // [RL1]
                IO_BIT_SET_OP: io_set = 1'b1; // [RL2]
                BIT_TO_TFLAG_OP: t_we = 1'b1; // [RL3]
                TFLAG_TO_BIT_OP: begin
                    op_we = 1'b1; // [RL4]
                    op_wdata = reg_val(OP_RD);
                    op_wdata[OP_BIT] = FLAGS[FLAG_T_POS];
                end
                FLAG_SET_OP: f_set = 1'b1; // [RL5]
                FLAG_CLEAR_OP: f_clr = 1'b1; // [RL5]
                REGISTER_COPY_OP: begin
                    op_we = 1'b1; // [RL16]
                    op_wdata = rr_val;
                end
                IMMEDIATE_LOAD_OP: op_we = 1'b1; // [RL16]
                INDIRECT_LOAD_OP: rd_go = 1'b1; // [RL6]
                INDIRECT_LOAD_INC_OP: begin
                    rd_go = 1'b1; // [RL6]
                    ptr_we = 1'b1; // [RL17]
                end
                INDIRECT_LOAD_DEC_OP, INDIRECT_WRITE_DEC_OP: begin
                    ptr_we = 1'b1; // [RL7] [RL9]
                    ptr_wval = ptr_cur - 16'h0001; // [RL17]
                end
                INDIRECT_WRITE_OP: mw_go = 1'b1; // [RL8]
                INDIRECT_WRITE_INC_OP: begin
                    mw_go = 1'b1; // [RL8]
                    ptr_we = 1'b1; // [RL17]
                end
                DIRECT_LOAD_OP: begin
                    rd_go = 1'b1; // [RL10]
                    rd_addr = OP_ADDR;
                end
                DIRECT_WRITE_OP: begin
                    mw_go = 1'b1; // [RL11]
                    mw_addr = OP_ADDR;
                end
                IO_READ_OP: begin
                    rd_go = 1'b1; // [RL12]
                    rd_io = 1'b1;
                end
                IO_WRITE_OP: io_w_go = 1'b1; // [RL12]
                STACK_SAVE_OP: begin
                    mw_go = 1'b1; // [RL13]
                    mw_addr = STACK_PTR;
                    sp_dec = 1'b1;
                end
                STACK_RESTORE_OP: sp_inc = 1'b1; // [RL14]
                default: op_we = 1'b0;
            endcase
        end else if (CLK_EN && state == S_PREDEC_LOAD) begin
            rd_go = 1'b1; // [RL7]
            rd_dst = held_rd;
            rd_addr = ptr_held;
        end else if (CLK_EN && state == S_RESTORE_READ) begin
            rd_go = 1'b1; // [RL14]
            rd_dst = held_rd;
            rd_addr = STACK_PTR;
        end else if (CLK_EN && state == S_PREDEC_WRITE) begin
            mw_go = 1'b1; // [RL9]
            mw_addr = ptr_held;
            mw_data = held_data;
        end
    end

    // Sequencer state and ready
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            state <= S_IDLE;
            OP_READY <= 1'b1;
        end else if (CLK_EN) begin
            state <= next_state;
            OP_READY <= (next_state == S_IDLE);
        end
    end

    // Operands kept for the later steps
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            held_rd <= 4'h0;
            held_lo <= 4'h0;
            held_data <= 8'h00;
        end else if (accept) begin
            held_rd <= OP_RD;
            held_lo <= ptr_lo;
            held_data <= rr_val;
        end
    end

    // Working register file; newest write wins
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            for (int i = 0; i < REG_COUNT; i++) regs[i] <= REG_RESET;
        end else if (CLK_EN) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                if (op_we && op_idx == 4'(i)) begin
                    regs[i] <= op_wdata; // [RL4] [RL16]
                end else if (ptr_we && ptr_lo == 4'(i)) begin
                    regs[i] <= ptr_wval[7:0]; // [RL17]
                end else if (ptr_we && ptr_hi == 4'(i)) begin
                    regs[i] <= ptr_wval[15:8]; // [RL17]
                end else if (wb_pend && wb_idx == 4'(i)) begin
                    regs[i] <= wb_data; // [RL10] [RL12]
                end
            end
        end
    end

    // Load data lands one edge after the read strobe
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            wb_pend <= 1'b0;
            wb_idx <= 4'h0;
            wb_from_io <= 1'b0;
        end else if (CLK_EN) begin
            wb_pend <= rd_go;
            wb_idx <= rd_dst;
            wb_from_io <= rd_io;
        end
    end

    // Data memory port
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            DMEM_ADDR <= 16'h0000;
            DMEM_WDATA <= 8'h00;
            DMEM_WE <= 1'b0;
            DMEM_RE <= 1'b0;
        end else if (CLK_EN) begin
            DMEM_WE <= mw_go;
            DMEM_RE <= rd_go && !rd_io;
            DMEM_WDATA <= mw_data;
            DMEM_ADDR <= mw_go ? mw_addr : rd_addr;
        end
    end

    // I/O space port, bit operations done by the addressed register
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            IO_ADDR <= 6'h00;
            IO_WDATA <= 8'h00;
            IO_WE <= 1'b0;
            IO_RE <= 1'b0;
            IO_BIT_MASK <= 8'h00;
            IO_BIT_CLR <= 1'b0;
            IO_BIT_SET <= 1'b0;
        end else if (CLK_EN) begin
            IO_WE <= io_w_go; // [RL12]
            IO_RE <= rd_go && rd_io; // [RL12]
            IO_BIT_CLR <= io_clr; // [RL1]
            IO_BIT_SET <= io_set; // [RL2]
            if (accept) begin
                IO_ADDR <= OP_ADDR[5:0];
                IO_WDATA <= rr_val;
                IO_BIT_MASK <= 8'h01 << OP_BIT;
            end
        end
    end

    // Stack pointer: post-decrement on save, pre-increment on restore
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            STACK_PTR <= STACK_RESET;
        end else if (CLK_EN && sp_dec) begin
            STACK_PTR <= STACK_PTR - 16'h0001; // [RL13]
        end else if (CLK_EN && sp_inc) begin
            STACK_PTR <= STACK_PTR + 16'h0001; // [RL14]
        end
    end

    // Control requests to other units, one-cycle pulses
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            BREAK_REQ <= 1'b0;
            SLEEP_REQ <= 1'b0;
            WDOG_KICK <= 1'b0;
        end else if (CLK_EN) begin
            BREAK_REQ <= accept && OP_CODE == DEBUG_HALT_OP; // [RL15]
            SLEEP_REQ <= accept && OP_CODE == LOW_POWER_OP; // [RL15]
            WDOG_KICK <= accept && OP_CODE == WATCHDOG_RESTART_OP; // [RL15]
        end
    end

    // Register observation port
    always_ff @(posedge CORE_CLK) begin
        if (SYS_RST) begin
            DBG_DATA <= 8'h00;
        end else if (CLK_EN) begin
            DBG_DATA <= regs[DBG_SEL];
        end
    end

    // Status flags
    bfdm_flags u_flags (
        .clk(CORE_CLK),
        .rst(SYS_RST),
        .en(CLK_EN),
        .set_en(f_set),
        .clr_en(f_clr),
        .sel(OP_BIT),
        .t_we(t_we),
        .t_val(rr_val[OP_BIT]),
        .flags(FLAGS)
    );

    a_bit_clear_io: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // [RL1]
        accept && OP_CODE == IO_BIT_CLEAR_OP |=> IO_BIT_CLR && !IO_BIT_SET && OP_READY
            && IO_BIT_MASK == (8'h01 << $past(OP_BIT)) && $stable(FLAGS))
        else $error("io bit clear wrong");
    a_bit_set_io: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // [RL2]
        accept && OP_CODE == IO_BIT_SET_OP |=> IO_BIT_SET && !IO_BIT_CLR && OP_READY
            && IO_ADDR == $past(OP_ADDR[5:0]) && $stable(FLAGS))
        else $error("io bit set wrong");
    a_tflag_copy: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // [RL3]
        accept && OP_CODE == BIT_TO_TFLAG_OP |=> FLAGS[FLAG_T_POS] == $past(rr_val[OP_BIT]))
        else $error("T flag not loaded from register bit");
    a_tflag_write: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // [RL4]
        accept && OP_CODE == TFLAG_TO_BIT_OP |=> regs[$past(OP_RD)] == $past(op_wdata)
            && regs[$past(OP_RD)][$past(OP_BIT)] == $past(FLAGS[FLAG_T_POS]) && $stable(FLAGS))
        else $error("T flag not written to register bit");
    a_load_inc: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || !CLK_EN) // [RL6]
        accept && OP_CODE == INDIRECT_LOAD_INC_OP |=> DMEM_RE && DMEM_ADDR == $past(ptr_cur)
            && !OP_READY ##1 OP_READY)
        else $error("post-increment load timing wrong");
    a_load_dec: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || !CLK_EN) // [RL7]
        accept && OP_CODE == INDIRECT_LOAD_DEC_OP |=> !DMEM_RE && !OP_READY
            ##1 DMEM_RE && DMEM_ADDR == $past(ptr_cur, 2) - 16'h0001 && !OP_READY ##1 OP_READY)
        else $error("pre-decrement load order wrong");
    a_write_dec: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || !CLK_EN) // [RL9]
        accept && OP_CODE == INDIRECT_WRITE_DEC_OP |=> !DMEM_WE && !OP_READY
            ##1 DMEM_WE && OP_READY && DMEM_ADDR == $past(ptr_cur, 2) - 16'h0001)
        else $error("pre-decrement store order wrong");
    a_direct_write: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // [RL11]
        accept && OP_CODE == DIRECT_WRITE_OP |=> DMEM_WE && OP_READY
            && DMEM_ADDR == $past(OP_ADDR) && DMEM_WDATA == $past(rr_val))
        else $error("direct store wrong");
    a_stack_save: assert property (@(posedge CORE_CLK) disable iff (SYS_RST || !CLK_EN) // [RL13]
        accept && OP_CODE == STACK_SAVE_OP |=> DMEM_WE && DMEM_ADDR == $past(STACK_PTR)
            && STACK_PTR == $past(STACK_PTR) - 16'h0001 && !OP_READY ##1 OP_READY && $stable(FLAGS))
        else $error("stack save wrong");
    a_control_single: assert property (@(posedge CORE_CLK) disable iff (SYS_RST) // [RL15]
        accept && (OP_CODE == LOW_POWER_OP || OP_CODE == DEBUG_HALT_OP || OP_CODE == IDLE_CYCLE_OP
            || OP_CODE == WATCHDOG_RESTART_OP) |=> OP_READY && $stable(FLAGS))
        else $error("control operation not single cycle");
endmodule
`default_nettype wire

// file: sim/bfdm_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module bfdm_mem_model (
    input wire logic clk,
    input wire logic [15:0] dmem_addr,
    input wire logic [7:0] dmem_wdata,
    input wire logic dmem_we,
    input wire logic dmem_re,
    output logic [7:0] dmem_rdata,
    input wire logic [5:0] io_addr,
    input wire logic [7:0] io_wdata,
    input wire logic io_we,
    input wire logic io_re,
    output logic [7:0] io_rdata,
    input wire logic [7:0] io_bit_mask,
    input wire logic io_bit_clr,
    input wire logic io_bit_set
);
    logic [7:0] dmem [0:255];
    logic [7:0] io [0:63];

    // Start from a known image
    initial begin
        foreach (dmem[i]) dmem[i] = 8'h00;
        foreach (io[i]) io[i] = 8'h00;
    end

    // Read data only valid while strobed, inverted otherwise
    assign dmem_rdata = dmem_re ? dmem[dmem_addr[7:0]] : ~dmem[dmem_addr[7:0]];
    assign io_rdata = io_re ? io[io_addr] : ~io[io_addr];

    // Writes and single-bit updates
    always @(posedge clk) begin
        if (dmem_we) dmem[dmem_addr[7:0]] <= dmem_wdata;
        if (io_we) io[io_addr] <= io_wdata;
        if (io_bit_clr) io[io_addr] <= io[io_addr] & ~io_bit_mask;
        if (io_bit_set) io[io_addr] <= io[io_addr] | io_bit_mask;
    end
endmodule
`default_nettype wire

// file: sim/test_bit_flag_and_data_move_exec.sv
`timescale 1ns/1ps
`default_nettype none
module test_bit_flag_and_data_move_exec;
    import bfdm_pkg::*;
    typedef struct {bfdm_op_type op; logic [3:0] rd; logic [3:0] rr; logic [2:0] bt; logic [7:0] imm;
        logic [15:0] adr; logic [1:0] ptr; int nc; int kd; int ix; logic [15:0] ex;} bfdm_row_type;
    localparam int KR = 0, KF = 1, KM = 2, KI = 3, KS = 4;
    logic clk, rst, clk_en, op_valid, op_ready, dmem_we, dmem_re, io_we, io_re, io_bit_clr, io_bit_set;
    logic break_req, sleep_req, wdog_kick;
    bfdm_op_type op_code;
    logic [3:0] op_rd, op_rr, dbg_sel;
    logic [2:0] op_bit;
    logic [7:0] op_imm, dmem_wdata, dmem_rdata, io_wdata, io_rdata, io_bit_mask, flags, dbg_data, rv, fexp;
    logic [15:0] op_addr, dmem_addr, stack_ptr, got;
    logic [1:0] op_ptr;
    logic [5:0] io_addr;
    int n_mismatch = 0, samples_checked = 0, last_nc;
    bfdm_row_type rows[$];

    bfdm_exec u_dut (.CORE_CLK(clk), .SYS_RST(rst), .CLK_EN(clk_en), .OP_VALID(op_valid), .OP_CODE(op_code),
        .OP_RD(op_rd), .OP_RR(op_rr), .OP_BIT(op_bit), .OP_IMM(op_imm), .OP_ADDR(op_addr), .OP_PTR(op_ptr),
        .OP_READY(op_ready), .DMEM_ADDR(dmem_addr), .DMEM_WDATA(dmem_wdata), .DMEM_WE(dmem_we),
        .DMEM_RE(dmem_re), .DMEM_RDATA(dmem_rdata), .IO_ADDR(io_addr), .IO_WDATA(io_wdata), .IO_WE(io_we),
        .IO_RE(io_re), .IO_RDATA(io_rdata), .IO_BIT_MASK(io_bit_mask), .IO_BIT_CLR(io_bit_clr),
        .IO_BIT_SET(io_bit_set), .FLAGS(flags), .STACK_PTR(stack_ptr), .BREAK_REQ(break_req),
        .SLEEP_REQ(sleep_req), .WDOG_KICK(wdog_kick), .DBG_SEL(dbg_sel), .DBG_DATA(dbg_data));

    bfdm_mem_model u_mem (.clk(clk), .dmem_addr(dmem_addr), .dmem_wdata(dmem_wdata), .dmem_we(dmem_we),
        .dmem_re(dmem_re), .dmem_rdata(dmem_rdata), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
        .io_re(io_re), .io_rdata(io_rdata), .io_bit_mask(io_bit_mask), .io_bit_clr(io_bit_clr),
        .io_bit_set(io_bit_set));

    // 25 MHz clock
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    // Compare and count
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        samples_checked++;
        if (g !== e) begin
            n_mismatch++;
            $display("mismatch at %0t: got %0h expected %0h", $time, g, e);
        end
    endtask

    // Verdict and end of run
    task automatic tally_and_finish;
        $display("comparisons %0d, mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Offer one op, hold until taken, then count cycles until ready again
    task automatic do_op(input bfdm_op_type op, input logic [3:0] rd, input logic [3:0] rr, input logic [2:0] bt,
        input logic [7:0] imm, input logic [15:0] adr, input logic [1:0] ptr);
        int k;
        @(negedge clk);
        op_valid = 1'b1;
        op_code = op;
        op_rd = rd;
        op_rr = rr;
        op_bit = bt;
        op_imm = imm;
        op_addr = adr;
        op_ptr = ptr;
        k = 0;
        while (op_ready !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
        end
        @(negedge clk);
        op_valid = 1'b0;
        last_nc = 1;
        while (op_ready !== 1'b1 && last_nc < 20) begin
            @(negedge clk);
            last_nc++;
        end
    endtask

    // Register file peek through the debug port
    task automatic rd_reg(input logic [3:0] ix, output logic [7:0] v);
        @(negedge clk);
        dbg_sel = ix;
        repeat (2) @(negedge clk);
        v = dbg_data;
    endtask

    task automatic add(input bfdm_op_type op, input logic [3:0] rd, input logic [3:0] rr, input logic [2:0] bt,
        input logic [7:0] imm, input logic [15:0] adr, input logic [1:0] ptr, input int nc, input int kd,
        input int ix, input logic [15:0] ex);
        rows.push_back('{op, rd, rr, bt, imm, adr, ptr, nc, kd, ix, ex});
    endtask

    // Hang guard
    initial begin
        #400000;
        n_mismatch++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        rst = 1'b1;
        clk_en = 1'b1;
        op_valid = 1'b0;
        op_code = IDLE_CYCLE_OP;
        op_rd = 4'h0;
        op_rr = 4'h0;
        op_bit = 3'h0;
        op_imm = 8'h00;
        op_addr = 16'h0000;
        op_ptr = 2'h0;
        dbg_sel = 4'h0;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        chk(flags, 8'h00);
        chk(stack_ptr, 16'h00FF);
        chk(op_ready, 1'b1);
        $display("test reset done");
        // Set each flag in turn, then clear each
        fexp = 8'h00;
        for (int i = 0; i < 16; i++) begin
            do_op(i < 8 ? FLAG_SET_OP : FLAG_CLEAR_OP, 4'h0, 4'h0, 3'(i), 8'h00, 16'h0000, 2'h0);
            fexp[i % 8] = (i < 8);
            chk(flags, fexp);
            chk(last_nc[15:0], 16'h0001);
        end
        $display("test flags done");
        add(IMMEDIATE_LOAD_OP, 1, 0, 0, 8'hA5, 0, 0, 1, KR, 1, 8'hA5);
        add(REGISTER_COPY_OP, 2, 1, 0, 0, 0, 0, 1, KR, 2, 8'hA5);
        add(BIT_TO_TFLAG_OP, 0, 1, 0, 0, 0, 0, 1, KF, 0, 8'h40);
        add(TFLAG_TO_BIT_OP, 3, 0, 7, 0, 0, 0, 1, KR, 3, 8'h80);
        add(DIRECT_WRITE_OP, 0, 1, 0, 0, 16'h0010, 0, 1, KM, 16, 8'hA5);
        add(DIRECT_LOAD_OP, 4, 0, 0, 0, 16'h0010, 0, 1, KR, 4, 8'hA5);
        add(IO_WRITE_OP, 0, 2, 0, 0, 16'h0005, 0, 1, KI, 5, 8'hA5);
        add(IO_BIT_CLEAR_OP, 0, 0, 0, 0, 16'h0005, 0, 1, KI, 5, 8'hA4);
        add(IO_BIT_SET_OP, 0, 0, 1, 0, 16'h0005, 0, 1, KI, 5, 8'hA6);
        add(IO_READ_OP, 5, 0, 0, 0, 16'h0005, 0, 1, KR, 5, 8'hA6);
        add(IMMEDIATE_LOAD_OP, 10, 0, 0, 8'h20, 0, 0, 1, KR, 10, 8'h20);
        add(IMMEDIATE_LOAD_OP, 11, 0, 0, 8'h00, 0, 0, 1, KR, 11, 8'h00);
        add(IMMEDIATE_LOAD_OP, 6, 0, 0, 8'h3C, 0, 0, 1, KR, 6, 8'h3C);
        add(INDIRECT_WRITE_INC_OP, 0, 1, 0, 0, 0, 0, 1, KM, 32, 8'hA5);
        add(INDIRECT_WRITE_DEC_OP, 0, 6, 0, 0, 0, 0, 2, KM, 32, 8'h3C);
        add(INDIRECT_LOAD_INC_OP, 7, 0, 0, 0, 0, 0, 2, KR, 10, 8'h21);
        add(INDIRECT_LOAD_DEC_OP, 8, 0, 0, 0, 0, 0, 3, KR, 8, 8'h3C);
        add(INDIRECT_LOAD_OP, 12, 0, 0, 0, 0, 0, 1, KR, 12, 8'h3C);
        add(INDIRECT_WRITE_OP, 0, 1, 0, 0, 0, 1, 1, KM, 60, 8'hA5);
        add(STACK_SAVE_OP, 0, 6, 0, 0, 0, 0, 2, KM, 255, 8'h3C);
        add(STACK_RESTORE_OP, 9, 0, 0, 0, 0, 0, 2, KR, 9, 8'h3C);
        add(IDLE_CYCLE_OP, 0, 0, 0, 0, 0, 0, 1, KS, 0, 16'h00FF);
        add(DEBUG_HALT_OP, 0, 0, 0, 0, 0, 0, 1, KF, 0, 8'h40);
        add(LOW_POWER_OP, 0, 0, 0, 0, 0, 0, 1, KF, 0, 8'h40);
        add(WATCHDOG_RESTART_OP, 0, 0, 0, 0, 0, 0, 1, KF, 0, 8'h40);
        add(IMMEDIATE_LOAD_OP, 14, 0, 0, 8'hFF, 0, 0, 1, KR, 14, 8'hFF);
        add(IMMEDIATE_LOAD_OP, 15, 0, 0, 8'hFF, 0, 0, 1, KR, 15, 8'hFF);
        add(INDIRECT_WRITE_INC_OP, 0, 1, 0, 0, 0, 2, 1, KR, 14, 8'h00);
        add(IDLE_CYCLE_OP, 0, 0, 0, 0, 0, 0, 1, KR, 15, 8'h00);
        add(BIT_TO_TFLAG_OP, 0, 3, 6, 0, 0, 0, 1, KF, 0, 8'h00);
        foreach (rows[i]) begin
            do_op(rows[i].op, rows[i].rd, rows[i].rr, rows[i].bt, rows[i].imm, rows[i].adr, rows[i].ptr);
            chk({13'h0, break_req, sleep_req, wdog_kick}, {13'h0, rows[i].op == DEBUG_HALT_OP,
                rows[i].op == LOW_POWER_OP, rows[i].op == WATCHDOG_RESTART_OP});
            chk(last_nc[15:0], rows[i].nc[15:0]);
            rd_reg(rows[i].ix[3:0], rv);
            case (rows[i].kd)
                KR: got = {8'h00, rv};
                KF: got = {8'h00, flags};
                KM: got = {8'h00, u_mem.dmem[rows[i].ix]};
                KI: got = {8'h00, u_mem.io[rows[i].ix]};
                default: got = stack_ptr;
            endcase
            chk(got, rows[i].ex);
        end
        chk(flags, 8'h00);
        $display("test table done");
        // Back to back: direct load then copy of the loaded register
        @(negedge clk);
        op_valid = 1'b1;
        op_code = DIRECT_LOAD_OP;
        op_rd = 4'hD;
        op_addr = 16'h0010;
        @(negedge clk);
        op_code = REGISTER_COPY_OP;
        op_rd = 4'hE;
        op_rr = 4'hD;
        @(negedge clk);
        op_valid = 1'b0;
        rd_reg(4'hE, rv);
        chk(rv, 8'hA5);
        $display("test back to back done");
        // Op offered while the clock enable is low is not taken
        @(negedge clk);
        clk_en = 1'b0;
        op_valid = 1'b1;
        op_code = IMMEDIATE_LOAD_OP;
        op_imm = 8'h77;
        repeat (3) @(negedge clk);
        op_valid = 1'b0;
        @(negedge clk);
        clk_en = 1'b1;
        rd_reg(4'hE, rv);
        chk(rv, 8'hA5);
        $display("test clock enable done");
        // Reset in mid-run
        @(negedge clk);
        rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        chk(flags, 8'h00);
        chk(stack_ptr, 16'h00FF);
        rd_reg(4'h1, rv);
        chk(rv, 8'h00);
        $display("test second reset done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
